// ---- hw/sgic_pkg.sv ----
// constants and helpers for the indirect serial-port register space
package sgic_pkg;

  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int BUS_W  = 32;

  typedef logic [ADDR_W-1:0] sgic_addr_t;
  typedef logic [DATA_W-1:0] sgic_word_t;
  typedef logic [1:0]        sgic_idx_t;

  // portal select values
  localparam logic PORTAL_ADDR = 1'b0;
  localparam logic PORTAL_DATA = 1'b1;

  // indirect addresses
  localparam sgic_addr_t CTRL_ADDR = 21'h1f0000;
  localparam sgic_addr_t STAT_ADDR = 21'h1f0001;
  localparam sgic_addr_t IDH_ADDR  = 21'h1f0002;
  localparam sgic_addr_t IDL_ADDR  = 21'h1f0003;
  localparam sgic_addr_t ADV_ADDR  = 21'h1f0004;
  localparam sgic_addr_t LPB_ADDR  = 21'h1f0005;
  localparam sgic_addr_t EXP_ADDR  = 21'h1f0006;
  localparam sgic_addr_t VDC_ADDR  = 21'h1f8000;
  localparam sgic_addr_t ANC_ADDR  = 21'h1f8001;
  localparam sgic_addr_t ANR_ADDR  = 21'h1f8002;

  // control register fields
  localparam int CTRL_RST_BIT     = 15;
  localparam int CTRL_LOOP_BIT    = 14;
  localparam int CTRL_SPD_LSB     = 13;
  localparam int CTRL_AN_EN_BIT   = 12;
  localparam int CTRL_PD_BIT      = 11;
  localparam int CTRL_RESTART_BIT = 9;
  localparam int CTRL_DUPLEX_BIT  = 8;
  localparam int CTRL_SPD_MSB     = 6;
  localparam sgic_word_t CTRL_RW_MASK   = 16'h7940;
  localparam sgic_word_t CTRL_RSVD_MASK = 16'h04bf;
  localparam sgic_word_t CTRL_RESET     = 16'h1140;

  // status register fields
  localparam sgic_word_t STAT_FIXED    = 16'h0189;
  localparam int         STAT_ANC_BIT  = 5;
  localparam int         STAT_RF_BIT   = 4;
  localparam int         STAT_LINK_BIT = 2;

  // storage slots for plain read/write words
  localparam int         STORE_DEPTH = 4;
  localparam sgic_idx_t  IDX_ADV     = 2'h0;
  localparam sgic_idx_t  IDX_EXP     = 2'h1;
  localparam sgic_idx_t  IDX_VDC     = 2'h2;
  localparam sgic_idx_t  IDX_ANC     = 2'h3;
  localparam sgic_word_t STORE_RESET = 16'h0000;

  // map an indirect address to {hit, slot}
  function automatic logic [2:0] sgic_slot(input sgic_addr_t a);
    logic [2:0] r;
    r = 3'h0;
    case (a)
      ADV_ADDR: r = {1'b1, IDX_ADV};
      EXP_ADDR: r = {1'b1, IDX_EXP};
      VDC_ADDR: r = {1'b1, IDX_VDC};
      ANC_ADDR: r = {1'b1, IDX_ANC};
      default:  r = 3'h0;
    endcase
    return r;
  endfunction : sgic_slot

endpackage : sgic_pkg

// ---- hw/sgic_store_if.sv ----
// carrier between the register block and its word storage
`timescale 1ns/10ps
`default_nettype none
interface sgic_store_if;
  import sgic_pkg::*;
  logic       wr;
  logic       rd;
  logic       clear;
  sgic_idx_t  wr_idx;
  sgic_idx_t  rd_idx;
  sgic_word_t wdata;
  sgic_word_t rdata;
  modport ctrl (output wr, rd, clear, wr_idx, rd_idx, wdata, input rdata);
  modport mem  (input wr, rd, clear, wr_idx, rd_idx, wdata, output rdata);
endinterface : sgic_store_if
`default_nettype wire

// ---- hw/sgic_store.sv ----
// small word store with registered read data
`timescale 1ns/10ps
`default_nettype none
module sgic_store
  import sgic_pkg::*;
(
  input  wire logic   sys_clk_in,
  input  wire logic   rst_n_in,
  sgic_store_if.mem   port
);

  sgic_word_t words [STORE_DEPTH];
  sgic_word_t rdata;

  assign port.rdata = rdata;

  // clear wins over a write so a soft reset leaves defaults behind
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < STORE_DEPTH; i++) begin
        words[i] <= STORE_RESET;
      end
    end else if (port.clear) begin
      for (int i = 0; i < STORE_DEPTH; i++) begin
        words[i] <= STORE_RESET;
      end
    end else if (port.wr) begin
      words[port.wr_idx] <= port.wdata;
    end
  end

  // read port independent of the write port
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata <= STORE_RESET;
    end else if (port.rd) begin
      rdata <= words[port.rd_idx];
    end
  end

endmodule : sgic_store
`default_nettype wire

// ---- hw/sgic_port_regs.sv ----
// portal-addressed register space of the serial gigabit port
`timescale 1ns/10ps
`default_nettype none
// Contract
// - indirect address space is 21 bits wide
// - access via address portal then data portal
// - standard and vendor registers at fixed addresses
// - soft reset bit restores defaults, self-clears
// - loopback bit loops fabric data in coding
// - speed from bits 6 and 13, default 1000
// - negotiation enable default one, restart self-clears
// - power-down bit stops port receiver, transmitter, clocks
// - link status latches low until status read
// - negotiation control applies after advertisement write
module sgic_port_regs
  import sgic_pkg::*;
#(
  parameter sgic_word_t ID_HIGH = 16'h0a5c,  // arbitrary identifier value
  parameter sgic_word_t ID_LOW  = 16'h3c10   // arbitrary identifier value
)(
  input  wire logic              sys_clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              portal_sel_in,
  input  wire logic              portal_wr_in,
  input  wire logic              portal_rd_in,
  input  wire logic [BUS_W-1:0]  portal_wdata_in,
  output var  logic [BUS_W-1:0]  portal_rdata_out,
  output var  logic              portal_rvalid_out,
  input  wire logic              rx_link_up_in,
  input  wire logic              an_complete_in,
  input  wire logic              remote_fault_in,
  input  wire sgic_word_t        partner_ability_in,
  input  wire sgic_word_t        an_result_in,
  output var  logic              sgmii_reset_out,
  output var  logic              loopback_out,
  output var  logic [1:0]        speed_out,
  output var  logic              an_enable_out,
  output var  logic              an_restart_out,
  output var  logic              power_down_out,
  output var  logic              full_duplex_out,
  output var  sgic_word_t        advertise_out,
  output var  sgic_word_t        an_control_out
);

  sgic_store_if store_bus ();

  sgic_store u_store (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .port       (store_bus.mem)
  );

  // state
  sgic_addr_t       portal_addr;
  sgic_word_t       ctrl;
  logic             soft_rst_pulse;
  logic             restart_pulse;
  logic             link_meta;
  logic             link_sync;
  logic             link_latched;
  logic             fault_latched;
  logic             commit_pend;
  sgic_word_t       adv_active;
  sgic_word_t       anc_active;
  logic             rd_stage;
  logic             rd_from_store;
  logic [BUS_W-1:0] rd_hold;

  // request decode; a write in the same cycle shadows a read
  logic       wr_addr_req;
  logic       ctrl_wr;
  logic       data_wr;
  logic       rd_taken;
  logic       data_rd;
  logic [2:0] slot;
  logic       slot_hit;
  sgic_idx_t  slot_idx;
  logic       adv_wr;
  logic       status_rd;
  logic       mapped;
  sgic_word_t wword;
  sgic_word_t next_ctrl;

  assign wword       = portal_wdata_in[DATA_W-1:0];
  assign wr_addr_req = portal_wr_in && (portal_sel_in == PORTAL_ADDR);
  assign data_wr     = portal_wr_in && (portal_sel_in == PORTAL_DATA);
  assign rd_taken    = portal_rd_in && !portal_wr_in;
  assign data_rd     = rd_taken && (portal_sel_in == PORTAL_DATA);
  assign slot        = sgic_slot(portal_addr);
  assign slot_hit    = slot[2];
  assign slot_idx    = slot[1:0];
  assign ctrl_wr     = data_wr && (portal_addr == CTRL_ADDR);
  assign adv_wr      = data_wr && (portal_addr == ADV_ADDR);
  assign status_rd   = data_rd && (portal_addr == STAT_ADDR);
  assign next_ctrl   = wword & CTRL_RW_MASK;

  // addresses answered on read
  assign mapped = slot_hit
               || (portal_addr == CTRL_ADDR) || (portal_addr == STAT_ADDR)
               || (portal_addr == IDH_ADDR)  || (portal_addr == IDL_ADDR)
               || (portal_addr == LPB_ADDR)  || (portal_addr == ANR_ADDR);

  // storage port: portal traffic, plus the commit read in the cycle of an advert write
  assign store_bus.wr     = data_wr && slot_hit && !soft_rst_pulse;
  assign store_bus.wr_idx = slot_idx;
  assign store_bus.wdata  = wword;
  assign store_bus.rd     = (data_rd && slot_hit) || adv_wr;
  assign store_bus.rd_idx = adv_wr ? IDX_ANC : slot_idx;
  assign store_bus.clear  = soft_rst_pulse;

  // address portal keeps exactly the indirect width
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      portal_addr <= '0;
    end else if (wr_addr_req) begin
      portal_addr <= portal_wdata_in[ADDR_W-1:0];
    end
  end

  // control register; the reset pulse overrides a write in its own cycle
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl <= CTRL_RESET;
    end else if (soft_rst_pulse) begin
      ctrl <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl <= next_ctrl;
    end
  end

  // self-clearing command bits live only as one-cycle pulses
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      soft_rst_pulse <= 1'b0;
      restart_pulse  <= 1'b0;
    end else begin
      soft_rst_pulse <= ctrl_wr && wword[CTRL_RST_BIT];
      restart_pulse  <= ctrl_wr && wword[CTRL_RESTART_BIT]
                        && !next_ctrl[CTRL_PD_BIT] && !soft_rst_pulse;
    end
  end

  // link level comes from the receiver, so two flops before use
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link_meta <= 1'b0;
      link_sync <= 1'b0;
    end else begin
      link_meta <= rx_link_up_in;
      link_sync <= link_meta;
    end
  end

  // latched-low link and latched-high fault; a new event beats the read clear
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link_latched  <= 1'b0;
      fault_latched <= 1'b0;
    end else if (soft_rst_pulse) begin
      link_latched  <= 1'b0;
      fault_latched <= 1'b0;
    end else begin
      link_latched  <= (status_rd || link_latched) && link_sync;
      fault_latched <= remote_fault_in || (fault_latched && !status_rd);
    end
  end

  // advert write applies itself and, one cycle later, the pending control
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      adv_active  <= STORE_RESET;
      anc_active  <= STORE_RESET;
      commit_pend <= 1'b0;
    end else if (soft_rst_pulse) begin
      adv_active  <= STORE_RESET;
      anc_active  <= STORE_RESET;
      commit_pend <= 1'b0;
    end else begin
      commit_pend <= adv_wr;
      if (adv_wr) begin
        adv_active <= wword;
      end
      if (commit_pend) begin
        anc_active <= store_bus.rdata;
      end
    end
  end

  // register views; command bits show their pulse, so they read back one only in the pulse cycle
  sgic_word_t ctrl_view;
  sgic_word_t stat_view;
  sgic_word_t direct_word;
  assign ctrl_view = ctrl
                   | (sgic_word_t'(soft_rst_pulse) << CTRL_RST_BIT)
                   | (sgic_word_t'(restart_pulse) << CTRL_RESTART_BIT);
  assign stat_view = STAT_FIXED
                   | (sgic_word_t'(an_complete_in) << STAT_ANC_BIT)
                   | (sgic_word_t'(fault_latched) << STAT_RF_BIT)
                   | (sgic_word_t'(link_latched) << STAT_LINK_BIT);
  assign direct_word = (portal_addr == CTRL_ADDR) ? ctrl_view :
                       (portal_addr == STAT_ADDR) ? stat_view :
                       (portal_addr == IDH_ADDR)  ? ID_HIGH :
                       (portal_addr == IDL_ADDR)  ? ID_LOW :
                       (portal_addr == LPB_ADDR)  ? partner_ability_in :
                       (portal_addr == ANR_ADDR)  ? an_result_in : '0;

  logic [BUS_W-1:0] rd_value;
  assign rd_value = (portal_sel_in == PORTAL_ADDR)
                  ? BUS_W'(portal_addr)
                  : BUS_W'(direct_word);

  // two-stage read: stage one waits for the storage word
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_stage      <= 1'b0;
      rd_from_store <= 1'b0;
      rd_hold       <= '0;
    end else begin
      rd_stage      <= rd_taken;
      rd_from_store <= data_rd && slot_hit;
      rd_hold       <= rd_value;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      portal_rdata_out  <= '0;
      portal_rvalid_out <= 1'b0;
    end else begin
      portal_rvalid_out <= rd_stage;
      if (rd_stage) begin
        portal_rdata_out <= rd_from_store ? BUS_W'(store_bus.rdata) : rd_hold;
      end
    end
  end

  // control outputs from the control register and the command pulses; advert and control words from their active copies
  assign sgmii_reset_out = soft_rst_pulse;
  assign loopback_out    = ctrl[CTRL_LOOP_BIT];
  assign speed_out       = {ctrl[CTRL_SPD_MSB], ctrl[CTRL_SPD_LSB]};
  assign an_enable_out   = ctrl[CTRL_AN_EN_BIT];
  assign an_restart_out  = restart_pulse;
  assign power_down_out  = ctrl[CTRL_PD_BIT];
  assign full_duplex_out = ctrl[CTRL_DUPLEX_BIT];
  assign advertise_out   = adv_active;
  assign an_control_out  = anc_active;

  // checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  chk_addr_width: assert property (
    rd_taken && (portal_sel_in == PORTAL_ADDR)
      |-> ##2 (portal_rdata_out[BUS_W-1:ADDR_W] == '0))
    else $error("address portal read shows bits above 21");

  // back-to-back reads are legal, so only the two-cycle answer is pinned
  chk_read_latency: assert property (
    rd_taken |-> ##2 portal_rvalid_out)
    else $error("read answer not two cycles after request");

  chk_rvalid_cause: assert property (
    portal_rvalid_out |-> $past(rd_taken, 2))
    else $error("read answer without a taken read");

  chk_unmapped_zero: assert property (
    data_rd && !mapped |-> ##2 (portal_rdata_out == '0))
    else $error("unmapped indirect address read non-zero");

  chk_soft_reset_clear: assert property (
    ctrl_wr && wword[CTRL_RST_BIT]
      |-> ##1 sgmii_reset_out ##1 (ctrl == CTRL_RESET && an_control_out == STORE_RESET))
    else $error("soft reset did not restore defaults");

  chk_loopback_follow: assert property (
    ctrl_wr && !wword[CTRL_RST_BIT] && !soft_rst_pulse
      |=> loopback_out == $past(wword[CTRL_LOOP_BIT]))
    else $error("loopback does not follow written bit");

  chk_speed_encode: assert property (
    ctrl_wr && !wword[CTRL_RST_BIT] && !soft_rst_pulse
      |=> speed_out == {$past(wword[CTRL_SPD_MSB]), $past(wword[CTRL_SPD_LSB])})
    else $error("speed bits mis-ordered");

  chk_restart_pulse: assert property (
    ctrl_wr && wword[CTRL_RESTART_BIT] && !wword[CTRL_PD_BIT] && !soft_rst_pulse
      |=> an_restart_out)
    else $error("restart write gave no pulse");

  chk_power_down: assert property (
    power_down_out |-> !an_restart_out)
    else $error("restart pulsed while powered down");

  chk_link_latch: assert property (
    status_rd && !link_latched |-> ##2 !portal_rdata_out[STAT_LINK_BIT])
    else $error("latched link drop lost before read");

  chk_adv_commit: assert property (
    $changed(an_control_out) |-> $past(commit_pend) || $past(soft_rst_pulse))
    else $error("negotiation control applied without advert write");

  chk_reserved_zero: assert property (
    data_rd && (portal_addr == CTRL_ADDR)
      |-> ##2 ((portal_rdata_out[DATA_W-1:0] & CTRL_RSVD_MASK) == '0))
    else $error("reserved control bits read non-zero");

  cov_soft_reset: cover property (ctrl_wr && wword[CTRL_RST_BIT] ##2 ctrl == CTRL_RESET);
  cov_restart:    cover property (an_restart_out);
  cov_link_low:   cover property (status_rd && !link_latched ##2 portal_rvalid_out);
  cov_commit:     cover property (adv_wr ##2 $changed(an_control_out));

endmodule : sgic_port_regs
`default_nettype wire

// ---- verification/sgic_link_partner.sv ----
// far-side link partner model: link level, negotiation outcome, fault events
`timescale 1ns/10ps
`default_nettype none
module sgic_link_partner
  import sgic_pkg::*;
#(
  parameter sgic_word_t ABILITY = 16'h4001,  // plain default
  parameter sgic_word_t RESULT  = 16'h2d01   // plain default, non-zero so a dead read shows
)(
  input  wire logic       sys_clk_in,
  input  wire logic       link_ok_in,
  input  wire logic       fault_in,
  output var  logic       rx_link_up_out,
  output var  logic       an_complete_out,
  output var  logic       remote_fault_out,
  output var  sgic_word_t ability_out,
  output var  sgic_word_t result_out
);
  logic [2:0] up_cnt = 3'h0;

  // negotiation ends some cycles after link-up, never at once
  always @(posedge sys_clk_in) begin
    up_cnt           <= #1 !link_ok_in ? 3'h0 : (up_cnt == 3'h4) ? up_cnt : up_cnt + 3'h1;
    rx_link_up_out   <= #1 link_ok_in;
    an_complete_out  <= #1 link_ok_in && (up_cnt == 3'h4);
    remote_fault_out <= #1 fault_in;
  end

  // words are only meaningful once negotiation is done; garbage before
  assign ability_out = an_complete_out ? ABILITY : ~ABILITY;
  assign result_out  = an_complete_out ? RESULT : ~RESULT;
endmodule : sgic_link_partner
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the portal register space
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sgic_pkg::*;
  logic             sys_clk_in, rst_n_in, sel, wr, rd, link_ok, fault;
  logic [BUS_W-1:0] wdata, rdata, got;
  logic             rvalid, link_up, an_done, rfault, srst, loop, anen, restart, pd, fdx;
  sgic_word_t       ability, result, adv, anc;
  logic [1:0]       speed;
  logic             snap_rst, snap_restart;
  int               err_total = 0;
  int               samples_checked = 0;

  sgic_port_regs #(.ID_HIGH(16'h1234), .ID_LOW(16'h5678)) dut_u (  // arbitrary ids
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .portal_sel_in(sel),
    .portal_wr_in(wr), .portal_rd_in(rd), .portal_wdata_in(wdata),
    .portal_rdata_out(rdata), .portal_rvalid_out(rvalid), .rx_link_up_in(link_up),
    .an_complete_in(an_done), .remote_fault_in(rfault), .partner_ability_in(ability),
    .an_result_in(result), .sgmii_reset_out(srst), .loopback_out(loop),
    .speed_out(speed), .an_enable_out(anen), .an_restart_out(restart),
    .power_down_out(pd), .full_duplex_out(fdx), .advertise_out(adv),
    .an_control_out(anc));

  sgic_link_partner partner_u (
    .sys_clk_in(sys_clk_in), .link_ok_in(link_ok), .fault_in(fault),
    .rx_link_up_out(link_up), .an_complete_out(an_done), .remote_fault_out(rfault),
    .ability_out(ability), .result_out(result));

  // clock at 4 ns
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  task automatic cyc(input int n = 1);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : cyc

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  task automatic end_sim;
    if (err_total == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  // address phase then data phase back to back; pulses sampled in their cycle
  task automatic wr_reg(input sgic_addr_t a, input sgic_word_t v);
    sel   = PORTAL_ADDR;
    wr    = 1'b1;
    wdata = {11'h000, a};
    cyc();
    sel   = PORTAL_DATA;
    wdata = {16'h0000, v};
    cyc();
    wr           = 1'b0;
    snap_rst     = srst;
    snap_restart = restart;
    cyc();
  endtask : wr_reg

  // read answer is due a fixed two edges after the data-portal strobe
  task automatic rd_reg(input sgic_addr_t a, input sgic_word_t want);
    sel   = PORTAL_ADDR;
    wr    = 1'b1;
    wdata = {11'h000, a};
    cyc();
    sel = PORTAL_DATA;
    wr  = 1'b0;
    rd  = 1'b1;
    cyc();
    rd = 1'b0;
    check(rvalid, 1'b0);
    cyc();
    check(rvalid, 1'b1);
    check(rdata, {16'h0000, want});
  endtask : rd_reg

  task automatic t_reset;
    check({loop, speed, anen, pd, fdx, srst, restart}, 8'h54);
    check({adv, anc}, 32'h0);
    rd_reg(CTRL_ADDR, 16'h1140);
  endtask : t_reset

  task automatic t_ctrl_bits;
    wr_reg(CTRL_ADDR, 16'h44bf);
    check({loop, speed, anen, fdx}, 5'h10);
    rd_reg(CTRL_ADDR, 16'h4000);
    wr_reg(CTRL_ADDR, 16'h2000);
    check(speed, 2'b01);
    wr_reg(CTRL_ADDR, 16'h2040);
    check(speed, 2'b11);
    wr_reg(CTRL_ADDR, 16'h0040);
    check(speed, 2'b10);
  endtask : t_ctrl_bits

  task automatic t_restart_pd;
    wr_reg(CTRL_ADDR, 16'h1340);
    check({snap_restart, restart}, 2'b10);
    rd_reg(CTRL_ADDR, 16'h1140);
    wr_reg(CTRL_ADDR, 16'h1b40);
    check({pd, snap_restart}, 2'b10);
    // main chip assumed awake already before the port's own bit is cleared
    wr_reg(CTRL_ADDR, 16'h1140);
    check(pd, 1'b0);
  endtask : t_restart_pd

  task automatic t_soft_reset;
    wr_reg(ADV_ADDR, 16'hbeef);
    wr_reg(VDC_ADDR, 16'h1234);
    wr_reg(CTRL_ADDR, 16'h4000);
    wr_reg(CTRL_ADDR, 16'hc000);
    check({snap_rst, srst, loop}, 3'b100);
    rd_reg(CTRL_ADDR, 16'h1140);
    rd_reg(VDC_ADDR, 16'h0000);
    check(adv, 16'h0000);
  endtask : t_soft_reset

  task automatic t_map;
    rd_reg(IDH_ADDR, 16'h1234);
    rd_reg(IDL_ADDR, 16'h5678);
    rd_reg(21'h1f0007, 16'h0000);
    wr_reg(LPB_ADDR, 16'h0bad);
    rd_reg(LPB_ADDR, ability);
    rd_reg(ANR_ADDR, result);
    wr_reg(EXP_ADDR, 16'h5a5a);
    rd_reg(EXP_ADDR, 16'h5a5a);
    // write with read in one cycle: the read must be dropped
    sel   = PORTAL_ADDR;
    wr    = 1'b1;
    rd    = 1'b1;
    wdata = 32'hffffffff;
    cyc();
    wr = 1'b0;
    rd = 1'b0;
    cyc(2);
    check(rvalid, 1'b0);
    rd = 1'b1;
    cyc();
    rd = 1'b0;
    cyc(2);
    check(rdata, 32'h001fffff);
  endtask : t_map

  task automatic t_commit;
    wr_reg(ANC_ADDR, 16'h00a5);
    check(anc, 16'h0000);
    wr_reg(ADV_ADDR, 16'h0180);
    check({adv, anc}, 32'h018000a5);
  endtask : t_commit

  task automatic t_status;
    rd_reg(STAT_ADDR, STAT_FIXED | 16'h0020);
    rd_reg(STAT_ADDR, STAT_FIXED | 16'h0024);
    link_ok = 1'b0;
    cyc(4);
    link_ok = 1'b1;
    cyc(10);
    rd_reg(STAT_ADDR, STAT_FIXED | 16'h0020);
    rd_reg(STAT_ADDR, STAT_FIXED | 16'h0024);
    fault = 1'b1;
    cyc();
    fault = 1'b0;
    cyc(3);
    rd_reg(STAT_ADDR, STAT_FIXED | 16'h0034);
    rd_reg(STAT_ADDR, STAT_FIXED | 16'h0024);
  endtask : t_status

  // software mirrors negotiated speed and duplex; serdes mode skips this
  task automatic t_sw_follow;
    rd_reg(ANR_ADDR, result);
    wr_reg(CTRL_ADDR, 16'h3100);
    check({speed, fdx}, 3'b011);
  endtask : t_sw_follow

  initial begin
    rst_n_in = 1'b0;
    sel      = 1'b0;
    wr       = 1'b0;
    rd       = 1'b0;
    wdata    = 32'h0;
    link_ok  = 1'b1;
    fault    = 1'b0;
    cyc(20);
    rst_n_in = 1'b1;
    t_reset();
    t_ctrl_bits();
    t_restart_pd();
    t_soft_reset();
    t_map();
    t_commit();
    t_status();
    t_sw_follow();
    end_sim();
  end

  // hang guard
  initial begin
    #100000;
    err_total++;
    end_sim();
  end
endmodule : tb
`default_nettype wire
